// ---- common/cmad_pkg.sv ----
/*
 * Constants shared by the CPU memory access decoder: the memory map, access
 * state counts, the sample I/O register offsets and the bit-operation codes.
 * Assumes a 16-bit byte address space with big-endian word order.
 */
// Notes on behaviour
// RL1: Reset or interrupt enters a transient exception state, leaving normal flow. Only interrupt entry does here; reset goes to ST_IDLE.
// RL2: Interrupt entry uses the stack pointer register, pushing PC and flags.
// RL3: Writes to unmapped regions update nothing; data is discarded.
// RL4: Reads from unmapped regions return undefined data.
// RL5: Peripheral transfers use an 8-bit data path only.
// RL6: Word write to I/O stores the upper byte and drops the lower.
// RL7: Word read from I/O gives register byte high, undefined low.
// RL8: Software should use byte transfers only for peripheral registers.
// RL9: Vectors at 0..0x0029; ROM ends at size-dependent top; two states.
// RL10: RAM 0xF780..0xFF7F accepts word and byte in two states.
// RL11: I/O from 0xFF90 byte only, two states; two windows take three.
// RL12: Bit instructions read the byte, change one bit, write it back.
// RL13: Shared address reads the counter and writes the reload register.
// RL14: Port read returns pin level for inputs, latch for outputs.
// RL15: Write-only bits read back as ones.
// RL16: Gaps after ROM and 0xFF80..0xFF8F behave as unmapped.
`default_nettype none
package cmad_pkg;

   // ------------------------------------------------------------------
   // Memory map
   // ------------------------------------------------------------------
   localparam logic [15:0] VEC_TOP_ADDR   = 16'h0029;
   localparam logic [15:0] ROM_TOP_48K    = 16'hBFFF;
   localparam logic [15:0] ROM_TOP_60K    = 16'hEDFF;
   localparam logic [15:0] RAM_BASE_ADDR  = 16'hF780;
   localparam logic [15:0] RAM_TOP_ADDR   = 16'hFF7F;
   localparam logic [15:0] IO_BASE_ADDR   = 16'hFF90;
   localparam logic [15:0] SLOW0_BASE     = 16'hFF98;
   localparam logic [15:0] SLOW0_TOP      = 16'hFF9F;
   localparam logic [15:0] SLOW1_BASE     = 16'hFFA8;
   localparam logic [15:0] SLOW1_TOP      = 16'hFFAF;
   localparam int          RAM_BYTES      = 2048;

   // Sample I/O registers at offsets within the I/O window.
   localparam logic [15:0] PORT_LATCH_ADDR = 16'hFFD6;
   localparam logic [15:0] PORT_DIR_ADDR   = 16'hFFE6;
   localparam logic [15:0] TIMER_ADDR      = 16'hFFB5;

   // ------------------------------------------------------------------
   // Access timing and reset values
   // ------------------------------------------------------------------
   localparam logic [1:0] STATES_FAST = 2'h2;
   localparam logic [1:0] STATES_SLOW = 2'h3;
   localparam logic [7:0] LATCH_RST   = 8'h00;
   localparam logic [7:0] DIR_RST     = 8'h00;
   localparam logic [7:0] RELOAD_RST  = 8'h00;
   localparam logic [7:0] UNDEF_BYTE  = 8'hFF;
   localparam logic [7:0] WO_ONES     = 8'hFF;

   // ------------------------------------------------------------------
   // Region and bit-operation codes
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      REG_VEC   = 3'h0,
      REG_ROM   = 3'h1,
      REG_RAM   = 3'h2,
      REG_IO    = 3'h3,
      REG_EMPTY = 3'h4
   } cmad_region_e;

   typedef enum logic [2:0] {
      BOP_SET   = 3'h0,
      BOP_CLR   = 3'h1,
      BOP_NOT   = 3'h2,
      BOP_ST    = 3'h3,
      BOP_IST   = 3'h4
   } cmad_bitop_e;

endpackage
`default_nettype wire

// ---- logic/cmad_ram.sv ----
/*
 * On-chip RAM store, 16 bits wide, byte-lane writes, registered read data.
 * Assumes the decoder hands it a word index already inside the RAM window.
 */
`timescale 1ns/1ps
`default_nettype none
module cmad_ram
   import cmad_pkg::*;
#(
   parameter int AW = 10
) (
   input  wire logic          i_core_clk,
   input  wire logic          i_we_hi,
   input  wire logic          i_we_lo,
   input  wire logic [AW-1:0] i_addr,
   input  wire logic [15:0]   i_wdata,
   output logic      [15:0]   o_rdata
);
   logic [15:0] mem_q [0:(1<<AW)-1];

   // Byte lanes are written independently so byte stores keep the other half.
   always_ff @(posedge i_core_clk) begin
      if (i_we_hi) begin
         mem_q[i_addr][15:8] <= i_wdata[15:8];
      end
      if (i_we_lo) begin
         mem_q[i_addr][7:0] <= i_wdata[7:0];
      end
      o_rdata <= mem_q[i_addr];
   end
endmodule // cmad_ram
`default_nettype wire

// ---- logic/cmad_sync.sv ----
/*
 * Three-flop input synchroniser for pin levels; output updates only when
 * the second and third stages agree.
 * Assumes asynchronous pins on the core clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module cmad_sync
   import cmad_pkg::*;
#(
   parameter int W = 8
) (
   input  wire logic         i_core_clk,
   input  wire logic         i_rst_n,
   input  wire logic [W-1:0] i_pin,
   output logic      [W-1:0] o_level
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // Stage one feeds only stage two, keeping metastability contained.
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s1_q    <= '0;
         s2_q    <= '0;
         s3_q    <= '0;
         o_level <= '0;
      end else begin
         s1_q <= i_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               o_level[i] <= s3_q[i];
            end
         end
      end
   end
endmodule // cmad_sync
`default_nettype wire

// ---- logic/cmad_decoder.sv ----
/*
 * CPU memory access decoder: region decode, two/three-state access timing,
 * byte-only peripheral path, RAM, sample port and timer registers, bit
 * read-modify-write sequencing and exception-entry stacking.
 * Assumes the CPU holds a request until o_done and ROM data is external.
 */
`timescale 1ns/1ps
`default_nettype none
module cmad_decoder
   import cmad_pkg::*;
#(
   parameter logic [15:0] ROM_TOP = ROM_TOP_60K
) (
   input  wire logic        i_core_clk,
   input  wire logic        i_rst_n,
   // CPU access request.
   input  wire logic        i_req,
   input  wire logic        i_we,
   input  wire logic        i_word,
   input  wire logic [15:0] i_addr,
   input  wire logic [15:0] i_wdata,
   output logic             o_done,
   output logic      [15:0] o_rdata,
   // Bit-manipulation request.
   input  wire logic        i_bit_req,
   input  wire logic [2:0]  i_bit_op,
   input  wire logic [2:0]  i_bit_num,
   input  wire logic        i_carry,
   // Exception entry.
   input  wire logic        i_irq_entry,
   input  wire logic [15:0] i_pc,
   input  wire logic [7:0]  i_condition_flag_register,
   input  wire logic [15:0] i_stack_pointer_register,
   output logic             o_exception,
   output logic      [15:0] o_stack_pointer_register,
   // ROM data path and region view.
   input  wire logic [15:0] i_rom_rdata,
   output logic      [2:0]  o_region,
   // Sample port and timer.
   input  wire logic [7:0]  i_port_pin,
   input  wire logic        i_timer_tick,
   output logic      [7:0]  o_port_output_latch,
   output logic      [7:0]  o_port_direction_control
);
   // ------------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------------
   // RL9 region decode
   function automatic cmad_region_e region_of(input logic [15:0] a);
      if (a <= VEC_TOP_ADDR) begin
         return REG_VEC;
      end else if (a <= ROM_TOP) begin
         return REG_ROM;
      // RL10 RAM window
      end else if (a >= RAM_BASE_ADDR && a <= RAM_TOP_ADDR) begin
         return REG_RAM;
      // RL11 I/O window
      end else if (a >= IO_BASE_ADDR) begin
         return REG_IO;
      end else begin
         // RL16 unused gaps
         return REG_EMPTY;
      end
   endfunction

   // RL11 three-state windows
   function automatic logic [1:0] states_of(input logic [15:0] a);
      if ((a >= SLOW0_BASE && a <= SLOW0_TOP) || (a >= SLOW1_BASE && a <= SLOW1_TOP)) begin
         return STATES_SLOW;
      end
      return STATES_FAST;
   endfunction

   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_ACC   = 3'h1,
      ST_RMW_R = 3'h2,
      ST_RMW_W = 3'h3,
      ST_EXC_P = 3'h4,
      ST_EXC_C = 3'h5
   } cmad_state_e;

   cmad_state_e  state_q;
   logic [1:0]   cnt_q;
   logic [15:0]  addr_q;
   logic [15:0]  wdata_q;
   logic         we_q;
   logic         word_q;
   logic [7:0]   rmw_q;
   logic [15:0]  sp_q;
   cmad_region_e reg_cur;
   logic         last_state;
   logic [7:0]   byte_rd;
   logic [7:0]   port_level;
   logic [7:0]   reload_q;
   logic [7:0]   counter_q;
   logic [15:0]  ram_rdata;
   logic         ram_we_hi;
   logic         ram_we_lo;
   logic         io_wr;
   logic [7:0]   io_wbyte;
   logic [7:0]   bit_new;

   assign reg_cur    = region_of(addr_q);
   assign last_state = (cnt_q == 2'h1);
   assign o_region   = reg_cur;
   assign o_stack_pointer_register = sp_q;

   // Counts down the states of the access in flight; re-armed per phase.
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= ST_IDLE;
         cnt_q   <= 2'h0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               // RL1 exception entry
               if (i_irq_entry) begin
                  state_q <= ST_EXC_P;
                  cnt_q   <= STATES_FAST;
               end else if (i_bit_req) begin
                  state_q <= ST_RMW_R;
                  cnt_q   <= states_of(i_addr);
               end else if (i_req) begin
                  state_q <= ST_ACC;
                  cnt_q   <= states_of(i_addr);
               end
            end
            ST_ACC: begin
               if (last_state) begin
                  state_q <= ST_IDLE;
               end
               cnt_q <= cnt_q - 2'h1;
            end
            ST_RMW_R: begin
               // RL12 read then write
               if (last_state) begin
                  state_q <= ST_RMW_W;
                  cnt_q   <= states_of(addr_q);
               end else begin
                  cnt_q <= cnt_q - 2'h1;
               end
            end
            ST_RMW_W: begin
               if (last_state) begin
                  state_q <= ST_IDLE;
               end
               cnt_q <= cnt_q - 2'h1;
            end
            ST_EXC_P: begin
               if (last_state) begin
                  state_q <= ST_EXC_C;
                  cnt_q   <= STATES_FAST;
               end else begin
                  cnt_q <= cnt_q - 2'h1;
               end
            end
            ST_EXC_C: begin
               if (last_state) begin
                  state_q <= ST_IDLE;
               end
               cnt_q <= cnt_q - 2'h1;
            end
            default: begin
               state_q <= ST_IDLE;
               cnt_q   <= 2'h0;
            end
         endcase
      end
   end

   // Captures request and, during exception entry, the push address/data.
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         addr_q  <= 16'h0000;
         wdata_q <= 16'h0000;
         we_q    <= 1'b0;
         word_q  <= 1'b0;
         sp_q    <= 16'h0000;
      end else if (state_q == ST_IDLE && i_irq_entry) begin
         // RL2 push PC then flags
         sp_q    <= i_stack_pointer_register - 16'h0002;
         addr_q  <= i_stack_pointer_register - 16'h0002;
         wdata_q <= i_pc;
         we_q    <= 1'b1;
         word_q  <= 1'b1;
      end else if (state_q == ST_EXC_P && last_state) begin
         sp_q    <= sp_q - 16'h0002;
         addr_q  <= sp_q - 16'h0002;
         wdata_q <= {i_condition_flag_register, i_condition_flag_register};
      end else if (state_q == ST_IDLE && (i_bit_req || i_req)) begin
         addr_q  <= i_addr;
         wdata_q <= i_wdata;
         we_q    <= i_req && !i_bit_req && i_we;
         word_q  <= i_req && !i_bit_req && i_word;
      end
   end

   assign o_exception = (state_q == ST_EXC_P) || (state_q == ST_EXC_C);

   // ------------------------------------------------------------------
   // Byte read mux for the I/O window
   // ------------------------------------------------------------------
   always_comb begin
      case (addr_q)
         // RL14 pin or latch
         PORT_LATCH_ADDR: byte_rd = (o_port_direction_control & o_port_output_latch) |
                                    (~o_port_direction_control & port_level);
         // RL15 write-only reads ones
         PORT_DIR_ADDR:   byte_rd = WO_ONES;
         // RL13 read gives counter
         TIMER_ADDR:      byte_rd = counter_q;
         default:         byte_rd = UNDEF_BYTE;
      endcase
   end

   // RL12 modify selected bit
   always_comb begin
      bit_new = rmw_q;
      case (cmad_bitop_e'(i_bit_op))
         BOP_SET: bit_new[i_bit_num] = 1'b1;
         BOP_CLR: bit_new[i_bit_num] = 1'b0;
         BOP_NOT: bit_new[i_bit_num] = ~rmw_q[i_bit_num];
         BOP_ST:  bit_new[i_bit_num] = i_carry;
         BOP_IST: bit_new[i_bit_num] = ~i_carry;
         default: bit_new = rmw_q;
      endcase
   end

   // Holds the byte read in the first phase of a bit instruction.
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rmw_q <= 8'h00;
      end else if (state_q == ST_RMW_R && last_state) begin
         rmw_q <= (reg_cur == REG_RAM) ? (addr_q[0] ? ram_rdata[7:0] : ram_rdata[15:8]) :
                  (reg_cur == REG_IO) ? byte_rd : UNDEF_BYTE;
      end
   end

   // ------------------------------------------------------------------
   // Write strobes
   // ------------------------------------------------------------------
   // RL3 no store outside RAM and I/O; RL16 gaps included
   always_comb begin
      ram_we_hi = 1'b0;
      ram_we_lo = 1'b0;
      io_wr     = 1'b0;
      io_wbyte  = wdata_q[15:8];
      if (last_state && reg_cur == REG_RAM) begin
         if (state_q == ST_ACC && we_q) begin
            ram_we_hi = word_q || !addr_q[0];
            ram_we_lo = word_q || addr_q[0];
         end else if (state_q == ST_EXC_P || state_q == ST_EXC_C) begin
            ram_we_hi = 1'b1;
            ram_we_lo = state_q == ST_EXC_P;
         end else if (state_q == ST_RMW_W) begin
            ram_we_hi = !addr_q[0];
            ram_we_lo = addr_q[0];
         end
      end
      if (last_state && reg_cur == REG_IO) begin
         // RL5 byte path; RL6 word keeps upper byte only
         io_wr    = (state_q == ST_ACC && we_q) || state_q == ST_RMW_W;
         io_wbyte = (state_q == ST_RMW_W) ? bit_new :
                    (word_q || !addr_q[0]) ? wdata_q[15:8] : wdata_q[7:0];
      end
   end

   // Sample I/O registers; timer counter runs on its tick.
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_port_output_latch      <= LATCH_RST;
         o_port_direction_control <= DIR_RST;
         reload_q                 <= RELOAD_RST;
         counter_q                <= RELOAD_RST;
      end else begin
         if (io_wr && addr_q == PORT_LATCH_ADDR) begin
            o_port_output_latch <= io_wbyte;
         end
         if (io_wr && addr_q == PORT_DIR_ADDR) begin
            o_port_direction_control <= io_wbyte;
         end
         // RL13 write loads reload
         if (io_wr && addr_q == TIMER_ADDR) begin
            reload_q <= io_wbyte;
         end
         if (i_timer_tick) begin
            counter_q <= (counter_q == 8'hFF) ? reload_q : counter_q + 8'h01;
         end
      end
   end

   // ------------------------------------------------------------------
   // Read data and completion
   // ------------------------------------------------------------------
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= 16'h0000;
      end else if (state_q == ST_ACC && last_state && !we_q) begin
         case (reg_cur)
            REG_VEC, REG_ROM: o_rdata <= i_rom_rdata;
            REG_RAM:          o_rdata <= word_q ? ram_rdata :
                                         addr_q[0] ? {ram_rdata[7:0], ram_rdata[7:0]} :
                                         {ram_rdata[15:8], ram_rdata[15:8]};
            // RL7 byte high, undefined low
            REG_IO:           o_rdata <= {byte_rd, UNDEF_BYTE};
            // RL4 undefined read
            default:          o_rdata <= {UNDEF_BYTE, UNDEF_BYTE};
         endcase
      end
   end

   // Done pulses one cycle after the final state of an access or sequence.
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_done <= 1'b0;
      end else begin
         o_done <= last_state && (state_q == ST_ACC || state_q == ST_RMW_W ||
                                  state_q == ST_EXC_C);
      end
   end

   // ------------------------------------------------------------------
   // Submodules
   // ------------------------------------------------------------------
   cmad_ram #(.AW(10)) u_ram (
      .i_core_clk (i_core_clk),
      .i_we_hi    (ram_we_hi),
      .i_we_lo    (ram_we_lo),
      .i_addr     (10'(addr_q[10:1] - RAM_BASE_ADDR[10:1])),
      .i_wdata    (state_q == ST_RMW_W ? {bit_new, bit_new} :
                   (!word_q && addr_q[0]) ? {wdata_q[7:0], wdata_q[7:0]} : wdata_q),
      .o_rdata    (ram_rdata)
   );

   cmad_sync #(.W(8)) u_sync (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_pin      (i_port_pin),
      .o_level    (port_level)
   );
endmodule // cmad_decoder
`default_nettype wire

// ---- dv/cmad_rom_model.sv ----
/*
 * Model of the program ROM that answers the decoder's ROM data path.
 * Assumes the bench routes the CPU address to it.
 */
`timescale 1ns/1ps
`default_nettype none
module cmad_rom_model (
   input  wire logic [15:0] i_addr,
   output logic      [15:0] o_rdata
);
   // ROM word data
   // The pattern differs in both bytes, so a swapped lane shows at once.
   assign o_rdata = i_addr ^ 16'hA5C3;
endmodule // cmad_rom_model
`default_nettype wire

// ---- dv/cmad_decoder_asserts.sv ----
/*
 * Port checker for the decoder: access lengths, read fill, stacking.
 * Assumes a CPU that holds i_req, i_we, i_word and i_addr until o_done.
 */
`timescale 1ns/1ps
`default_nettype none
module cmad_decoder_asserts
   import cmad_pkg::*;
(
   input wire logic        i_core_clk,
   input wire logic        i_rst_n,
   input wire logic        i_req,
   input wire logic        i_we,
   input wire logic        i_word,
   input wire logic [15:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic        i_bit_req,
   input wire logic        i_irq_entry,
   input wire logic [15:0] i_stack_pointer_register,
   input wire logic        o_done,
   input wire logic [15:0] o_rdata,
   input wire logic        o_exception,
   input wire logic [15:0] o_stack_pointer_register,
   input wire logic [2:0]  o_region,
   input wire logic [7:0]  o_port_output_latch
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);

   AST_MEM_TWO:
      assert property ($rose(i_req) ##1 (o_region inside {REG_VEC, REG_ROM, REG_RAM})
         |-> !o_done[*2] ##1 o_done) else $error("Memory access length wrong.");
   AST_IO_TWO:
      assert property ($rose(i_req) ##1 (o_region == REG_IO && !(i_addr inside
         {[SLOW0_BASE:SLOW0_TOP], [SLOW1_BASE:SLOW1_TOP]})) |-> !o_done[*2] ##1 o_done)
         else $error("Fast I/O access length wrong.");
   AST_IO_THREE:
      assert property ($rose(i_req) ##1 (i_addr inside
         {[SLOW0_BASE:SLOW0_TOP], [SLOW1_BASE:SLOW1_TOP]}) |-> !o_done[*3] ##1 o_done)
         else $error("Slow I/O access length wrong.");
   AST_EMPTY_READ:
      assert property (o_done && $past(i_req) && !i_we && o_region == REG_EMPTY
         |-> o_rdata == 16'hFFFF) else $error("Unmapped read data wrong.");
   AST_IO_LOW:
      assert property (o_done && $past(i_req) && !i_we && o_region == REG_IO
         |-> o_rdata[7:0] == UNDEF_BYTE) else $error("I/O read low byte wrong.");
   AST_WO_ONES:
      assert property (o_done && $past(i_req) && !i_we && i_addr == PORT_DIR_ADDR
         |-> o_rdata[15:8] == WO_ONES) else $error("Write-only bits not ones.");
   AST_IO_WORD_WR:
      assert property (o_done && $past(i_req) && i_we && i_word && i_addr == PORT_LATCH_ADDR
         |-> o_port_output_latch == i_wdata[15:8]) else $error("Word write lane wrong.");
   AST_BIT_RMW:
      assert property ($rose(i_bit_req) |-> !o_done[*5] ##[1:3] o_done)
         else $error("Bit operation length wrong.");
   AST_EXC_ENTER:
      assert property ($rose(i_irq_entry) |=> o_exception)
         else $error("Exception state not entered.");
   AST_EXC_STACK:
      assert property ($rose(i_irq_entry) |-> ##5 o_done ##1
         (o_stack_pointer_register == i_stack_pointer_register - 16'h0004))
         else $error("Exception stacking wrong.");
endmodule // cmad_decoder_asserts

bind cmad_decoder cmad_decoder_asserts i_chk (
   .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_req(i_req), .i_we(i_we),
   .i_word(i_word), .i_addr(i_addr), .i_wdata(i_wdata), .i_bit_req(i_bit_req),
   .i_irq_entry(i_irq_entry), .i_stack_pointer_register(i_stack_pointer_register),
   .o_done(o_done), .o_rdata(o_rdata), .o_exception(o_exception),
   .o_stack_pointer_register(o_stack_pointer_register), .o_region(o_region),
   .o_port_output_latch(o_port_output_latch)
);
`default_nettype wire

// ---- dv/tb.sv ----
/*
 * Self-checking bench for the decoder: RAM lanes, ROM, gaps, port, bit ops.
 * Assumes the ROM model on the ROM data path and the checker bound in.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
   $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb;
   import cmad_pkg::*;
   logic        clk = 0, rst_n = 0, req = 0, we = 0, word = 0, brq = 0, carry = 0, irq = 0;
   logic [15:0] addr = 0, wdata = 0, pc = 0, sp = 0, a, d, rom_d, rdata, sp_o;
   logic [7:0]  condition_flag_register = 0, pins = 8'h40, v, latch, dirc;
   logic [2:0]  bop = 0, bnum = 0, region;
   logic        done, exc, tick = 0;
   logic [31:0] seed = 32'h07D1C058;
   logic [16:0] exp_q[$];
   logic [16:0] note;
   int          fails = 0, num_checks = 0;

   cmad_rom_model i_rom (.i_addr(addr), .o_rdata(rom_d));
   cmad_decoder i_dut (
      .i_core_clk(clk), .i_rst_n(rst_n), .i_req(req), .i_we(we), .i_word(word),
      .i_addr(addr), .i_wdata(wdata), .o_done(done), .o_rdata(rdata),
      .i_bit_req(brq), .i_bit_op(bop), .i_bit_num(bnum), .i_carry(carry),
      .i_irq_entry(irq), .i_pc(pc), .i_condition_flag_register(condition_flag_register),
      .i_stack_pointer_register(sp), .o_exception(exc), .o_stack_pointer_register(sp_o),
      .i_rom_rdata(rom_d), .o_region(region), .i_port_pin(pins), .i_timer_tick(tick),
      .o_port_output_latch(latch), .o_port_direction_control(dirc));

   // Free-running 100 MHz clock.
   initial forever #5 clk = ~clk;

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // One CPU access; the note goes in first so the watcher can pair it.
   task automatic acc(input logic w, input logic wd, input logic [15:0] ad,
                      input logic [15:0] dat, input logic c, input logic [15:0] e);
      int n;
      @(negedge clk);
      exp_q.push_back({c, e});
      we = w;
      word = wd;
      addr = ad;
      wdata = dat;
      req = 1;
      n = 0;
      do begin @(negedge clk); n++; end while (done !== 1'b1 && n < 20);
      req = 0;
      `CHK(n, (ad inside {[SLOW0_BASE:SLOW0_TOP], [SLOW1_BASE:SLOW1_TOP]}) ? 4 : 3)
   endtask

   // Bit operation or exception entry, both ending in o_done.
   task automatic op(input logic is_irq, input logic [15:0] ad, input logic [2:0] o,
                     input logic [2:0] bn);
      int n;
      @(negedge clk);
      exp_q.push_back(17'h00000);
      addr = ad;
      bop = o;
      bnum = bn;
      if (is_irq) irq = 1;
      else brq = 1;
      n = 0;
      do begin @(negedge clk); n++; end while (done !== 1'b1 && n < 20);
      irq = 0;
      brq = 0;
      `CHK(n < 20, 1'b1)
   endtask

   task automatic conclude();
      $display("Checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Watcher: every completion takes the oldest note off the queue.
   always @(negedge clk) begin
      if (done === 1'b1 && exp_q.size() > 0) begin
         note = exp_q.pop_front();
         if (note[16]) `CHK(rdata, note[15:0])
      end
   end

   // Watchdog; the run needs well under a thousand cycles.
   initial begin
      #100000;
      fails++;
      conclude();
   end

   initial begin
      repeat (4) @(negedge clk);
      rst_n = 1;
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         a = (i == 0) ? RAM_TOP_ADDR - 16'h0001 : RAM_BASE_ADDR + {5'h00, seed[10:1], 1'b0};
         d = seed[31:16];
         acc(1, 1, a, d, 0, 16'h0000);
         acc(0, 1, a, 16'h0000, 1, d);
         acc(0, 0, a, 16'h0000, 1, {2{d[15:8]}});
         acc(1, 0, a + 16'h0001, 16'h005A, 0, 16'h0000);
         acc(0, 1, a, 16'h0000, 1, {d[15:8], 8'h5A});
      end
      acc(1, 1, 16'h1000, 16'h1111, 0, 16'h0000);
      acc(0, 1, 16'h1000, 16'h0000, 1, 16'h1000 ^ 16'hA5C3);
      acc(0, 1, 16'h0028, 16'h0000, 1, 16'h0028 ^ 16'hA5C3);
      acc(0, 1, ROM_TOP_60K - 16'h0001, 16'h0000, 1, 16'hEDFE ^ 16'hA5C3);
      acc(1, 1, ROM_TOP_60K + 16'h0001, 16'h1234, 0, 16'h0000);
      acc(0, 1, ROM_TOP_60K + 16'h0001, 16'h0000, 1, 16'hFFFF);
      acc(0, 0, 16'hFF80, 16'h0000, 1, 16'hFFFF);
      acc(0, 0, 16'hFF8F, 16'h0000, 1, 16'hFFFF);
      // pins and latch mixed; byte-only I/O
      acc(1, 0, PORT_DIR_ADDR, 16'h3F00, 0, 16'h0000);
      acc(1, 0, PORT_LATCH_ADDR, 16'h8000, 0, 16'h0000);
      acc(0, 0, PORT_LATCH_ADDR, 16'h0000, 1, 16'h40FF);
      op(0, PORT_LATCH_ADDR, BOP_SET, 3'h0);
      `CHK(latch, 8'h41)
      acc(0, 0, PORT_DIR_ADDR, 16'h0000, 1, 16'hFFFF);
      op(0, PORT_DIR_ADDR, BOP_CLR, 3'h0);
      `CHK(dirc, 8'hFE)
      acc(1, 1, PORT_LATCH_ADDR, 16'h5A3C, 0, 16'h0000);
      `CHK(latch, 8'h5A)
      acc(0, 1, PORT_LATCH_ADDR, 16'h0000, 1, 16'h5AFF);
      acc(0, 0, SLOW0_BASE, 16'h0000, 0, 16'h0000);
      acc(0, 0, SLOW1_TOP, 16'h0000, 0, 16'h0000);
      acc(1, 0, PORT_DIR_ADDR, 16'hFF00, 0, 16'h0000);
      acc(1, 0, PORT_LATCH_ADDR, 16'h0000, 0, 16'h0000);
      v = 8'h00;
      for (int k = 0; k < 5; k++) begin
         seed = xs(seed);
         carry = seed[0];
         case (k)
            0: v[3] = 1'b1;
            1: v[3] = 1'b0;
            2: v[3] = ~v[3];
            3: v[3] = carry;
            default: v[3] = ~carry;
         endcase
         op(0, PORT_LATCH_ADDR, k[2:0], 3'h3);
         `CHK(latch, v)
      end
      // write loads reload, read shows counter
      acc(1, 0, TIMER_ADDR, 16'h0055, 0, 16'h0000);
      acc(0, 0, TIMER_ADDR, 16'h0000, 1, 16'h00FF);
      // 256 ticks run the counter from zero through its wrap into the reload value.
      tick = 1;
      repeat (256) @(negedge clk);
      tick = 0;
      acc(0, 0, TIMER_ADDR, 16'h0000, 1, 16'h55FF);
      sp = 16'hFF7E;
      pc = 16'h1234;
      condition_flag_register = 8'hA5;
      op(1, 16'h0000, BOP_SET, 3'h0);
      acc(0, 1, 16'hFF7C, 16'h0000, 1, 16'h1234);
      acc(0, 0, 16'hFF7A, 16'h0000, 1, 16'hA5A5);
      `CHK(sp_o, 16'hFF7A)
      conclude();
   end
endmodule // tb
`default_nettype wire
